/* File: logic/ccs_card_clock_ctrl.sv */
/*
 ccs_card_clock_ctrl: card clock generator, configuration latch and
 open-drain card line translator of a smartcard interface.
 assumes all pin inputs are asynchronous to clk; clk is at least several
 times faster than the async and sync card clock inputs.
*/
//
// Behaviour
// R1 - program supply and clock while ready low, selected
// R2 - latch configuration on chip select rising edge
// R3 - async mode divides input clock by 1/2/4
// R4 - switched pulses never shorter or longer than either (code: only between async settings; a switch to or from sync can cut a phase)
// R5 - sync mode holds last level on deselect
// R6 - sync clock passes only while selected
// R7 - divided clock keeps running while deselected
// R8 - buffered async clock copy on own pin
// R9 - finish current card clock cycle before switching
// R10 - first cycle after reset has full length
// R11 - host prefers divide 2/4 for asymmetric clocks
// R12 - selected and powered: lines transparent both ways
// R13 - card lines are open drain, pulled low
// R14 - deselected and powered: card lines keep level
// R15 - supply off forces card lines low
// R16 - deselected: host pins released, card side held
// R17 - deselect enters standby, supply converter stopped
// R18 - host parks control pins during standby
// R19 - host stops input clocks during standby
// R20 - host gives each device own chip select
// R21 - switch only while low, start with high (code: a switch to sync starts at the sync level, low while deselected)
`timescale 1ns/1ps
`default_nettype none
module ccs_card_clock_ctrl
   import ccs_pkg::*;
#(
   parameter int NUM_LINES = CCS_NUM_LINES
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic async_clock_in,
   input wire logic sync_clock_in,
   input wire logic chipSelect_n,
   input wire logic ready_mode_line,
   input wire logic power_request,
   input wire logic cardResetIn,
   input wire logic supplyReady,
   input wire logic [NUM_LINES-1:0] hostLineIn,
   output logic [NUM_LINES-1:0] hostLineOut,
   output logic [NUM_LINES-1:0] hostLineOe,
   input wire logic [NUM_LINES-1:0] cardLineIn,
   output logic [NUM_LINES-1:0] cardLineOut,
   output logic [NUM_LINES-1:0] cardLineOe,
   output logic card_clock_out,
   output logic clock_buffer_out,
   output logic card_supply,
   output logic standby,
   output logic [1:0] clockSelect
);
   localparam int SW = 6 + 2 * NUM_LINES;

   // data line doubles as a programming input
   function automatic ccs_clk_sel_t decodeSel(input logic dataBit, input logic rstBit);
      ccs_clk_sel_t sel;
      sel = SEL_SYNC;
      unique case ({dataBit, rstBit})
         2'h0: sel = SEL_SYNC;
         2'h1: sel = SEL_DIV1;
         2'h2: sel = SEL_DIV2;
         2'h3: sel = SEL_DIV4;
      endcase
      return sel;
   endfunction

   logic [SW-1:0] syncQ;
   logic asyncS, syncS, csS, rdyS, pwrS, rstS;
   logic readyS;
   logic [NUM_LINES-1:0] hostS, cardS;

   ccs_sync #(
      .W(SW)
   ) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .d({cardLineIn, hostLineIn, supplyReady, cardResetIn, power_request,
          ~ready_mode_line, ~chipSelect_n, sync_clock_in}),
      .rstVal({SW{1'h0}}),
      .q(syncQ)
   );

   assign syncS = syncQ[0];
   // idle-high pins synced inverted: zero reset reads deselected, no false program
   assign csS = ~syncQ[1];
   assign rdyS = ~syncQ[2];
   assign pwrS = syncQ[3];
   assign rstS = syncQ[4];
   assign readyS = syncQ[5];
   assign hostS = syncQ[6 +: NUM_LINES];
   assign cardS = syncQ[6 + NUM_LINES +: NUM_LINES];

   // async clock kept apart: it also feeds the buffered copy
   logic asyncMeta;
   logic next_asyncMeta, next_asyncS;

   // edge history and configuration
   logic asyncPrev, syncPrev, csPrev;
   logic shadowPwr;
   ccs_clk_sel_t shadowSel, pendingSel;
   logic supplyOn;
   logic next_asyncPrev, next_syncPrev, next_csPrev;
   logic next_shadowPwr;
   ccs_clk_sel_t next_shadowSel, next_pendingSel;
   logic next_supplyOn;
   logic next_standby;
   logic next_bufOut;
   logic aRise, syncRise, csRise, progMode;

   assign aRise = asyncS & ~asyncPrev;
   assign syncRise = syncS & ~syncPrev;
   assign csRise = csS & ~csPrev;
   assign progMode = ~rdyS & ~csS;

   always_comb begin
      next_asyncMeta = async_clock_in;
      next_asyncS = asyncMeta;
      next_asyncPrev = asyncS;
      next_syncPrev = syncS;
      next_csPrev = csS;
      next_bufOut = asyncS; // R8
      next_standby = csS; // R17
      next_shadowPwr = shadowPwr;
      next_shadowSel = shadowSel;
      next_supplyOn = supplyOn;
      next_pendingSel = pendingSel;
      if (progMode) begin
         next_shadowPwr = pwrS; // R1
         next_shadowSel = decodeSel(hostS[CCS_LINE_DATA], rstS); // R1
      end
      if (csRise) begin
         next_supplyOn = shadowPwr; // R2
         next_pendingSel = shadowSel; // R2
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         // reset high so a pin already high at release is no rising edge
         asyncMeta <= 1'h1; // R10
         asyncS <= 1'h1;
         asyncPrev <= 1'h1;
         syncPrev <= 1'h0;
         csPrev <= 1'h1;
         clock_buffer_out <= 1'h0;
         standby <= 1'h0;
         shadowPwr <= CCS_RST_SUPPLY;
         shadowSel <= CCS_RST_SEL;
         supplyOn <= CCS_RST_SUPPLY;
         pendingSel <= CCS_RST_SEL;
      end else begin
         asyncMeta <= next_asyncMeta;
         asyncS <= next_asyncS;
         asyncPrev <= next_asyncPrev;
         syncPrev <= next_syncPrev;
         csPrev <= next_csPrev;
         clock_buffer_out <= next_bufOut;
         standby <= next_standby;
         shadowPwr <= next_shadowPwr;
         shadowSel <= next_shadowSel;
         supplyOn <= next_supplyOn;
         pendingSel <= next_pendingSel;
      end
   end

   assign card_supply = supplyOn;

   // card clock generator
   ccs_clk_state_t ckState, next_ckState;
   ccs_clk_sel_t activeSel, next_activeSel;
   logic divPhase, next_divPhase;
   logic next_cardClk;
   logic lowEnd;

   // end of the current low phase for the active source
   always_comb begin
      lowEnd = 1'h0;
      unique case (activeSel)
         SEL_SYNC: lowEnd = csS ? aRise : syncRise;
         SEL_DIV1: lowEnd = aRise;
         SEL_DIV2: lowEnd = aRise & ~card_clock_out;
         SEL_DIV4: lowEnd = aRise & ~card_clock_out & (divPhase == CCS_DIV4_LAST_RISE);
      endcase
   end

   always_comb begin
      next_ckState = ckState;
      next_activeSel = activeSel;
      next_divPhase = divPhase;
      next_cardClk = card_clock_out;
      unique case (ckState)
         CK_IDLE: begin
            // wait for a clean input edge so the first cycle is whole
            if (aRise) begin
               next_ckState = CK_RUN;
               next_activeSel = pendingSel; // R10
               next_divPhase = CCS_RST_DIV_PHASE;
               next_cardClk = (pendingSel == SEL_SYNC) ? (syncS & ~csS) : 1'h1; // R10
            end
         end
         CK_RUN: begin
            if (!card_clock_out && lowEnd && (pendingSel != activeSel)) begin
               next_activeSel = pendingSel; // R9 R21
               next_divPhase = CCS_RST_DIV_PHASE;
               next_cardClk = (pendingSel == SEL_SYNC) ? (syncS & ~csS) : 1'h1; // R4 R21
            end else begin
               unique case (activeSel)
                  SEL_SYNC: begin
                     // deselect freezes the level, card data stays consistent
                     if (!csS) begin
                        next_cardClk = syncS; // R6
                     end // R5
                  end
                  SEL_DIV1: next_cardClk = asyncS; // R3 R7
                  SEL_DIV2: begin
                     if (aRise) begin
                        next_cardClk = ~card_clock_out; // R3 R7
                     end
                  end
                  SEL_DIV4: begin
                     if (aRise) begin
                        if (divPhase == CCS_DIV4_LAST_RISE) begin
                           next_cardClk = ~card_clock_out; // R3 R7
                           next_divPhase = CCS_RST_DIV_PHASE;
                        end else begin
                           next_divPhase = CCS_DIV4_LAST_RISE;
                        end
                     end
                  end
               endcase
            end
         end
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ckState <= CK_IDLE;
         activeSel <= CCS_RST_SEL;
         divPhase <= CCS_RST_DIV_PHASE;
         card_clock_out <= CCS_RST_CLOCK;
         clockSelect <= 2'h0;
      end else begin
         ckState <= next_ckState;
         activeSel <= next_activeSel;
         divPhase <= next_divPhase;
         card_clock_out <= next_cardClk;
         clockSelect <= next_activeSel;
      end
   end

   // open-drain line translator
   ccs_line_state_t lnState [NUM_LINES];
   ccs_line_state_t next_lnState [NUM_LINES];
   logic [NUM_LINES-1:0] next_hostOe, next_cardOe;
   logic transparent;

   assign transparent = ~csS & supplyOn & readyS;

   always_comb begin
      for (int i = 0; i < NUM_LINES; i++) begin
         next_lnState[i] = lnState[i];
         next_hostOe[i] = 1'h0;
         next_cardOe[i] = cardLineOe[i];
         if (!supplyOn) begin
            next_lnState[i] = LN_IDLE;
            next_cardOe[i] = 1'h1; // R15
         end else if (csS) begin
            next_cardOe[i] = cardLineOe[i]; // R14 R16
            next_hostOe[i] = 1'h0; // R16
         end else if (!transparent) begin
            // start sequence still running: card side held low
            next_lnState[i] = LN_IDLE;
            next_cardOe[i] = 1'h1;
         end else begin
            // the side that pulled first owns the line, echo ignored
            unique case (lnState[i])
               LN_IDLE: begin
                  if (!hostS[i]) begin
                     next_lnState[i] = LN_HOST_LOW; // R12
                  end else if (!cardS[i]) begin
                     next_lnState[i] = LN_CARD_LOW; // R12
                  end
               end
               LN_HOST_LOW: begin
                  if (hostS[i]) begin
                     next_lnState[i] = LN_WAIT_CARD;
                  end
               end
               LN_CARD_LOW: begin
                  if (cardS[i]) begin
                     next_lnState[i] = LN_WAIT_HOST;
                  end
               end
               LN_WAIT_HOST: begin
                  if (hostS[i]) begin
                     next_lnState[i] = LN_IDLE;
                  end
               end
               LN_WAIT_CARD: begin
                  if (cardS[i]) begin
                     next_lnState[i] = LN_IDLE;
                  end
               end
               default: next_lnState[i] = LN_IDLE;
            endcase
            next_cardOe[i] = (next_lnState[i] == LN_HOST_LOW); // R13
            next_hostOe[i] = (next_lnState[i] == LN_CARD_LOW); // R13
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         for (int i = 0; i < NUM_LINES; i++) begin
            lnState[i] <= LN_IDLE;
         end
         hostLineOe <= '0;
         cardLineOe <= '1;
         hostLineOut <= '0;
         cardLineOut <= '0;
      end else begin
         for (int i = 0; i < NUM_LINES; i++) begin
            lnState[i] <= next_lnState[i];
         end
         hostLineOe <= next_hostOe;
         cardLineOe <= next_cardOe;
         // open drain: only ever pulls low
         hostLineOut <= '0; // R13
         cardLineOut <= '0; // R13
      end
   end
endmodule
`default_nettype wire

/* File: logic/ccs_pkg.sv */
/*
 ccs_pkg: shared types and constants of the card clock and select control.
 assumes a single 125 MHz system clock and an active-low asynchronous reset.
*/
`default_nettype none
package ccs_pkg;
   localparam int CCS_CLK_PERIOD_NS = 8;
   localparam int CCS_SYNC_STAGES = 2;
   localparam int CCS_NUM_LINES = 3;
   localparam int CCS_LINE_DATA = 0;
   localparam int CCS_LINE_AUX_ONE = 1;
   localparam int CCS_LINE_AUX_TWO = 2;
   localparam logic CCS_RST_SUPPLY = 1'h0;
   localparam logic CCS_RST_CLOCK = 1'h0;
   localparam logic CCS_RST_DIV_PHASE = 1'h0;
   localparam logic CCS_DIV4_LAST_RISE = 1'h1;

   // card clock source and divide ratio
   typedef enum logic [1:0] {
      SEL_SYNC,
      SEL_DIV1,
      SEL_DIV2,
      SEL_DIV4
   } ccs_clk_sel_t;

   localparam ccs_clk_sel_t CCS_RST_SEL = SEL_DIV1;

   typedef enum logic {
      CK_IDLE,
      CK_RUN
   } ccs_clk_state_t;

   // ownership of one open-drain card line
   typedef enum logic [2:0] {
      LN_IDLE,
      LN_HOST_LOW,
      LN_CARD_LOW,
      LN_WAIT_HOST,
      LN_WAIT_CARD
   } ccs_line_state_t;
endpackage
`default_nettype wire

/* File: logic/ccs_sync.sv */
/*
 ccs_sync: a bank of two-flop synchronisers.
 assumes inputs are asynchronous pins; only the last stage is read outside.
*/
`timescale 1ns/1ps
`default_nettype none
module ccs_sync
   import ccs_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   input wire logic [W-1:0] rstVal,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_q;

   always_comb begin
      next_meta = d;
      next_q = meta;
   end

   // reset value fixed at zero; the rstVal port is not used
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= next_meta;
         q <= next_q;
      end
   end

   logic unusedRst;
   assign unusedRst = |rstVal;
endmodule
`default_nettype wire

/* File: bench/ccs_chk_sva.sv */
/*
 ccs_chk: port-level assertions of the card clock and select control.
 assumes an async clock half period of ASYNC_HALF clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module ccs_chk
   import ccs_pkg::*;
#(
   parameter int NUM_LINES = 3,
   parameter int ASYNC_HALF = 5
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic chipSelect_n,
   input wire logic async_clock_in,
   input wire logic supplyReady,
   input wire logic [NUM_LINES-1:0] hostLineOut,
   input wire logic [NUM_LINES-1:0] hostLineOe,
   input wire logic [NUM_LINES-1:0] cardLineOe,
   input wire logic card_clock_out,
   input wire logic clock_buffer_out,
   input wire logic card_supply,
   input wire logic standby,
   input wire logic [1:0] clockSelect
);
   int hiCnt, next_hiCnt, stillCnt, next_stillCnt, hiExp;
   logic prevClk;
   logic [1:0] prevSel;
   always_comb begin
      next_hiCnt = card_clock_out ? hiCnt + 1 : 0;
      // a new selection restarts the idle count
      next_stillCnt = (card_clock_out != prevClk || clockSelect != prevSel) ? 0 : stillCnt + 1;
      hiExp = ASYNC_HALF << (int'(clockSelect) - 1);
   end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hiCnt <= 0;
         stillCnt <= 0;
         prevClk <= 1'b0;
         prevSel <= 2'h0;
      end else begin
         hiCnt <= next_hiCnt;
         stillCnt <= next_stillCnt;
         prevClk <= card_clock_out;
         prevSel <= clockSelect;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   chk_buf_copy: assert property ($rose(async_clock_in) |-> ##[1:4] clock_buffer_out)
      else $error("buffered clock late");
   chk_standby_sel: assert property (chipSelect_n [*5] |-> standby)
      else $error("standby missing");
   chk_host_free: assert property (standby && $past(standby) |-> hostLineOe == '0)
      else $error("host line driven deselected");
   chk_host_open: assert property (hostLineOut == '0)
      else $error("host line driven high");
   chk_supply_low: assert property (!card_supply [*3] |-> cardLineOe == '1)
      else $error("card lines not forced low");
   chk_card_keep: assert property ((standby && card_supply && supplyReady) [*3]
      |-> $stable(cardLineOe))
      else $error("card line changed deselected");
   chk_sync_hold: assert property ((standby && clockSelect == SEL_SYNC) [*3]
      |-> $stable(card_clock_out))
      else $error("sync clock not held");
   chk_pulse_len: assert property ($fell(card_clock_out) && clockSelect != SEL_SYNC
      |-> hiCnt >= hiExp - 1 && hiCnt <= hiExp + 1)
      else $error("card clock high phase wrong");
   chk_keep_run: assert property (clockSelect != SEL_SYNC |-> stillCnt <= 4 * ASYNC_HALF + 4)
      else $error("divided clock stalled");
endmodule
bind ccs_card_clock_ctrl ccs_chk #(.NUM_LINES(NUM_LINES), .ASYNC_HALF(5)) chk (.clk(clk),
   .reset_n(reset_n), .chipSelect_n(chipSelect_n), .async_clock_in(async_clock_in),
   .supplyReady(supplyReady), .hostLineOut(hostLineOut), .hostLineOe(hostLineOe),
   .cardLineOe(cardLineOe), .card_clock_out(card_clock_out),
   .clock_buffer_out(clock_buffer_out), .card_supply(card_supply), .standby(standby),
   .clockSelect(clockSelect));
`default_nettype wire

/* File: bench/ccs_card_model.sv */
/*
 ccs_card_model: clock sources and card-side open-drain wires.
 assumes 80 ns async period, 64 ns sync period, unrelated to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ccs_card_model (
   input wire logic syncRun,
   input wire logic [2:0] cardLineOe,
   input wire logic [2:0] cardPull,
   output logic async_clock_in,
   output logic sync_clock_in,
   output logic [2:0] cardLineIn
);
   initial begin
      async_clock_in = 1'b0;
      #3;
      forever #40 async_clock_in = ~async_clock_in;
   end
   initial begin
      sync_clock_in = 1'b0;
      #5;
      // parked low when stopped
      forever #32 sync_clock_in = syncRun ? ~sync_clock_in : 1'b0;
   end
   assign cardLineIn = ~(cardLineOe | cardPull);
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
/*
 tb_top: self-checking bench of ccs_card_clock_ctrl.
 assumes ccs_card_model supplies clocks and the card-side wires.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import ccs_pkg::*;
   logic clk, reset_n, chipSelect_n, ready_mode_line, power_request, cardResetIn;
   logic supplyReady, syncRun, card_clock_out, clock_buffer_out, card_supply, standby;
   logic async_clock_in, sync_clock_in;
   logic [2:0] hostPull, cardPull, hostLineIn, hostLineOut, hostLineOe;
   logic [2:0] cardLineIn, cardLineOut, cardLineOe;
   logic [1:0] clockSelect;
   int num_errors, checks_done, r;
   assign hostLineIn = ~(hostLineOe | hostPull);
   ccs_card_model model (.syncRun(syncRun), .cardLineOe(cardLineOe), .cardPull(cardPull),
      .async_clock_in(async_clock_in), .sync_clock_in(sync_clock_in), .cardLineIn(cardLineIn));
   ccs_card_clock_ctrl uut (.clk(clk), .reset_n(reset_n), .async_clock_in(async_clock_in),
      .sync_clock_in(sync_clock_in), .chipSelect_n(chipSelect_n),
      .ready_mode_line(ready_mode_line), .power_request(power_request),
      .cardResetIn(cardResetIn), .supplyReady(supplyReady), .hostLineIn(hostLineIn),
      .hostLineOut(hostLineOut), .hostLineOe(hostLineOe), .cardLineIn(cardLineIn),
      .cardLineOut(cardLineOut), .cardLineOe(cardLineOe), .card_clock_out(card_clock_out),
      .clock_buffer_out(clock_buffer_out), .card_supply(card_supply), .standby(standby),
      .clockSelect(clockSelect));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic rises(int n, output int cnt);
      logic p;
      cnt = 0;
      p = card_clock_out;
      repeat (n) begin
         cyc(1);
         if (card_clock_out === 1'b1 && p === 1'b0) cnt++;
         p = card_clock_out;
      end
   endtask
   // data wire carries bit 1 of the selection, reset pin bit 0
   task automatic load_config(logic sup, logic [1:0] sel);
      int i;
      ready_mode_line = 1'b0;
      chipSelect_n = 1'b0;
      power_request = sup;
      hostPull[0] = ~sel[1];
      cardResetIn = sel[0];
      cyc(8);
      chipSelect_n = 1'b1;
      cyc(8);
      ready_mode_line = 1'b1;
      hostPull[0] = 1'b0;
      check("supply", card_supply, sup);
      for (i = 0; i < 200 && clockSelect !== sel; i++) cyc(1);
      check("select", clockSelect, sel);
   endtask
   task automatic test_modes;
      for (int s = 1; s < 4; s++) begin
         load_config(1'b1, 2'(s));
         rises(400, r);
         check("rate", 4'(r >= (40 >> (s - 1)) - 1 && r <= (40 >> (s - 1)) + 1), 4'h1);
         check("standby", standby, 1'b1);
      end
      $display("test_modes done");
   endtask
   task automatic test_refused;
      chipSelect_n = 1'b0;
      cardResetIn = 1'b0;
      hostPull[0] = 1'b1;
      cyc(8);
      chipSelect_n = 1'b1;
      hostPull[0] = 1'b0;
      cyc(60);
      check("refused", clockSelect, SEL_DIV4);
      $display("test_refused done");
   endtask
   task automatic test_sync;
      load_config(1'b1, SEL_SYNC);
      chipSelect_n = 1'b0;
      syncRun = 1'b1;
      cyc(6);
      rises(200, r);
      check("sync follow", 4'(r >= 24 && r <= 26), 4'h1);
      chipSelect_n = 1'b1;
      cyc(6);
      rises(100, r);
      check("sync held", 4'(r), 4'h0);
      syncRun = 1'b0;
      cyc(8);
      $display("test_sync done");
   endtask
   task automatic test_lines;
      supplyReady = 1'b0;
      chipSelect_n = 1'b0;
      cyc(8);
      check("not ready", cardLineOe, 3'h7);
      supplyReady = 1'b1;
      cyc(16);
      check("card idle", cardLineIn, 3'h7);
      check("card open", cardLineOut, 3'h0);
      hostPull = 3'h2;
      cyc(8);
      check("host to card", cardLineIn, 3'h5);
      hostPull = 3'h0;
      cyc(8);
      check("card free", cardLineIn, 3'h7);
      cardPull = 3'h4;
      cyc(8);
      check("card to host", hostLineIn, 3'h3);
      cardPull = 3'h0;
      hostPull = 3'h1;
      cyc(8);
      chipSelect_n = 1'b1;
      cyc(6);
      hostPull = 3'h0;
      cyc(8);
      check("card kept", cardLineIn, 3'h6);
      check("host free", hostLineOe, 3'h0);
      load_config(1'b0, SEL_SYNC);
      check("forced low", cardLineOe, 3'h7);
      $display("test_lines done");
   endtask
   initial begin
      {reset_n, chipSelect_n, ready_mode_line, power_request, cardResetIn} = 5'h08;
      {supplyReady, syncRun, hostPull, cardPull} = 8'h00;
      num_errors = 0;
      checks_done = 0;
      cyc(10);
      check("reset oe", cardLineOe, 3'h7);
      reset_n = 1'b1;
      supplyReady = 1'b1;
      cyc(4);
      test_modes();
      test_refused();
      test_sync();
      test_lines();
      stop_test();
   end
   // whole run is some 1800 clk cycles
   initial begin
      #100000;
      num_errors++;
      $display("[ERR] watchdog expected done seen hang");
      stop_test();
   end
endmodule
`default_nettype wire
